//--- perf_monitor_counters.sv
// per-channel performance-monitor error counter bank with register port and interrupt
// Contract
// (R1) count receive excessive zero violations in a 16-bit accumulator since last read
// (R2) reading excessive zero bytes returns count and restarts it from zero
// (R3) upper byte bits 15..8 readable at channel offset 0x910
// (R4) lower byte bits 7..0 readable at channel offset 0x911
// (R5) host reads upper byte before lower byte to get and clear count
// (R6) each signalling controller has an 8-bit leaky-bucket FCS counter, clear on read, resets zero
// (R7) signalling FCS counters for controllers one to three at 0x912, 0x913, 0x914
// (R8) 8-bit counter at 0x91C counts second LAPD controller FCS errors
// (R9) 8-bit counter at 0x92C counts third LAPD controller FCS errors
// (R10) reading a LAPD FCS counter returns value and clears it; both reset zero
// (R11) upper-byte read captures lower byte for a consistent following lower read
// (R12) counters saturate at maximum instead of wrapping
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "perf_monitor_consts.svh"
module perf_monitor_counters
   import perf_monitor_pkg::*;
#(
   parameter int NUM_SIGNALLING = 3
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic excess_zero_event,
   input wire logic [NUM_SIGNALLING-1:0] signalling_fcs_event,
   input wire logic lapd_two_fcs_event,
   input wire logic lapd_three_fcs_event,
   input wire logic leak_tick,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic irq
);

   // ****************************************************************
   // address decode: the top nibble selects the channel and is ignored
   // ****************************************************************
   logic [11:0] ofs;
   logic rd_high;
   logic rd_low;
   logic rd_lapd_two;
   logic rd_lapd_three;
   logic rd_status;
   logic wr_status;
   logic wr_mask;
   logic wr_leak;
   logic [NUM_SIGNALLING-1:0] rd_sig;

   assign ofs = addr[11:0];
   assign rd_high = rd && (ofs == `OFS_EXCESS_ZERO_COUNT_HIGH); // R3
   assign rd_low = rd && (ofs == `OFS_EXCESS_ZERO_COUNT_LOW); // R4
   assign rd_lapd_two = rd && (ofs == `OFS_LAPD_TWO_FCS_ERRORS); // R8
   assign rd_lapd_three = rd && (ofs == `OFS_LAPD_THREE_FCS_ERRORS); // R9
   assign rd_status = rd && (ofs == `OFS_IRQ_STATUS);
   assign wr_status = wr && (ofs == `OFS_IRQ_STATUS);
   assign wr_mask = wr && (ofs == `OFS_IRQ_MASK);
   assign wr_leak = wr && (ofs == `OFS_BUCKET_LEAK_PERIOD);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SIGNALLING; gi++)
      begin : g_sig_dec
         assign rd_sig[gi] = rd && (ofs == (`OFS_SIGNALLING_FCS_CTRL1 + 12'(gi))); // R7
      end
   endgenerate

   // ****************************************************************
   // counters
   // ****************************************************************
   word_type ez_count;
   logic ez_sat;
   byte_type lapd_two_count;
   byte_type lapd_three_count;
   logic lapd_two_sat;
   logic lapd_three_sat;
   byte_type sig_count [NUM_SIGNALLING];
   logic [NUM_SIGNALLING-1:0] sig_sat;
   logic leak_pulse;

   // the live counter clears on the upper read; the lower byte is served from the snapshot
   sat_counter #(.WIDTH(16)) u_excess_zero
   (
      .clk(clk),
      .resetn(resetn),
      .event_in(excess_zero_event), // R1
      .clear(rd_high), // R2 R5
      .count(ez_count),
      .saturated(ez_sat)
   );

   sat_counter #(.WIDTH(8)) u_lapd_two
   (
      .clk(clk),
      .resetn(resetn),
      .event_in(lapd_two_fcs_event),
      .clear(rd_lapd_two), // R10
      .count(lapd_two_count),
      .saturated(lapd_two_sat)
   );

   sat_counter #(.WIDTH(8)) u_lapd_three
   (
      .clk(clk),
      .resetn(resetn),
      .event_in(lapd_three_fcs_event),
      .clear(rd_lapd_three), // R10
      .count(lapd_three_count),
      .saturated(lapd_three_sat)
   );

   generate
      for (gi = 0; gi < NUM_SIGNALLING; gi++)
      begin : g_sig
         leaky_bucket u_bucket
         (
            .clk(clk),
            .resetn(resetn),
            .event_in(signalling_fcs_event[gi]),
            .leak_tick(leak_pulse),
            .clear(rd_sig[gi]), // R6
            .count(sig_count[gi]),
            .saturated(sig_sat[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // register state
   // ****************************************************************
   typedef struct packed
   {
      byte_type low_snap;
      read_phase_type phase;
      byte_type rdata;
      byte_type status;
      byte_type mask;
      byte_type leak_period;
      byte_type leak_cnt;
      logic leak_pulse;
   } state_type;

   state_type state_q;
   state_type state_d;
   byte_type events;

   always_comb
   begin
      events = `IRQ_RESET;
      events[`IRQ_BIT_EXCESS_ZERO] = excess_zero_event;
      events[`IRQ_BIT_SIGNALLING_FCS] = |signalling_fcs_event;
      events[`IRQ_BIT_LAPD_TWO] = lapd_two_fcs_event;
      events[`IRQ_BIT_LAPD_THREE] = lapd_three_fcs_event;
      events[`IRQ_BIT_SATURATED] = ez_sat | lapd_two_sat | lapd_three_sat | (|sig_sat);
   end

   always_comb
   begin
      state_d = state_q;
      state_d.rdata = 8'h00;
      state_d.leak_pulse = 1'b0;

      // leak divider: one tick per (leak_period+1) external leak ticks
      if (leak_tick)
      begin
         if (state_q.leak_cnt >= state_q.leak_period)
         begin
            state_d.leak_cnt = 8'h00;
            state_d.leak_pulse = 1'b1;
         end
         else
         begin
            state_d.leak_cnt = state_q.leak_cnt + 8'h01;
         end
      end

      if (rd_high)
      begin
         state_d.rdata = ez_count[`EXCESS_ZERO_HIGH_MSB:`EXCESS_ZERO_HIGH_LSB]; // R3
         state_d.low_snap = ez_count[7:0]; // R11
         state_d.phase = RD_HIGH_DONE;
      end
      else if (rd_low)
      begin
         // without a prior upper read the snapshot holds 00; software must keep the order
         state_d.rdata = state_q.low_snap; // R4 R5 R11
         state_d.low_snap = `COUNT8_RESET; // R2
         state_d.phase = RD_IDLE;
      end
      else if (rd_lapd_two)
      begin
         state_d.rdata = lapd_two_count; // R8
      end
      else if (rd_lapd_three)
      begin
         state_d.rdata = lapd_three_count; // R9
      end
      else if (rd_status)
      begin
         state_d.rdata = state_q.status;
      end
      else if (rd && (ofs == `OFS_IRQ_MASK))
      begin
         state_d.rdata = state_q.mask;
      end
      else if (rd && (ofs == `OFS_BUCKET_LEAK_PERIOD))
      begin
         state_d.rdata = state_q.leak_period;
      end
      else
      begin
         for (int i = 0; i < NUM_SIGNALLING; i++)
         begin
            if (rd_sig[i])
            begin
               state_d.rdata = sig_count[i]; // R7
            end
         end
      end

      if (wr_mask)
      begin
         state_d.mask = wdata;
      end
      if (wr_leak)
      begin
         state_d.leak_period = wdata;
      end

      // write-one-to-clear; a new event in the same cycle wins
      state_d.status = (state_q.status & ~(wr_status ? wdata : 8'h00)) | events;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q.low_snap <= `COUNT8_RESET;
         state_q.phase <= RD_IDLE;
         state_q.rdata <= 8'h00;
         state_q.status <= `IRQ_RESET;
         state_q.mask <= `IRQ_RESET;
         state_q.leak_period <= `LEAK_PERIOD_RESET;
         state_q.leak_cnt <= 8'h00;
         state_q.leak_pulse <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign leak_pulse = state_q.leak_pulse;
   assign rdata = state_q.rdata;
   assign irq = |(state_q.status & state_q.mask);

endmodule // perf_monitor_counters

//--- perf_monitor_consts.svh
// offsets, field positions, reset values and interrupt bit positions of the performance-monitor counter bank
`ifndef PERF_MONITOR_CONSTS_SVH
`define PERF_MONITOR_CONSTS_SVH

// ****************************************************************
// register offsets within one channel (low 12 bits of the address)
// ****************************************************************
`define OFS_EXCESS_ZERO_COUNT_HIGH 12'h910
`define OFS_EXCESS_ZERO_COUNT_LOW 12'h911
`define OFS_SIGNALLING_FCS_CTRL1 12'h912
`define OFS_SIGNALLING_FCS_CTRL2 12'h913
`define OFS_SIGNALLING_FCS_CTRL3 12'h914
`define OFS_LAPD_TWO_FCS_ERRORS 12'h91C
`define OFS_LAPD_THREE_FCS_ERRORS 12'h92C
`define OFS_IRQ_STATUS 12'h930
`define OFS_IRQ_MASK 12'h931
`define OFS_BUCKET_LEAK_PERIOD 12'h932

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define EXCESS_ZERO_HIGH_MSB 15
`define EXCESS_ZERO_HIGH_LSB 8
`define COUNT8_RESET 8'h00
`define COUNT16_RESET 16'h0000
`define LEAK_PERIOD_RESET 8'hFF
`define IRQ_RESET 8'h00

// interrupt status bit positions
`define IRQ_BIT_EXCESS_ZERO 0
`define IRQ_BIT_SIGNALLING_FCS 1
`define IRQ_BIT_LAPD_TWO 2
`define IRQ_BIT_LAPD_THREE 3
`define IRQ_BIT_SATURATED 4

`endif

//--- perf_monitor_pkg.sv
// types shared by the performance-monitor counter bank
package perf_monitor_pkg;

   typedef logic [7:0] byte_type;
   typedef logic [15:0] word_type;

   typedef enum logic [1:0]
   {
      RD_IDLE = 2'b00,
      RD_HIGH_DONE = 2'b01
   } read_phase_type;

endpackage

//--- sat_counter.sv
// saturating clear-on-read event counter
`timescale 1ns/10ps
module sat_counter
   import perf_monitor_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic event_in,
   input wire logic clear,
   output logic [WIDTH-1:0] count,
   output logic saturated
);

   typedef struct packed
   {
      logic [WIDTH-1:0] cnt;
   } state_type;

   state_type state_q;
   state_type state_d;

   always_comb
   begin
      state_d = state_q;
      if (clear)
      begin
         // an event in the clearing cycle is kept as the first count
         state_d.cnt = event_in ? WIDTH'(1) : '0;
      end
      else if (event_in && (state_q.cnt != {WIDTH{1'b1}})) // R12
      begin
         state_d.cnt = state_q.cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign count = state_q.cnt;
   assign saturated = event_in && (state_q.cnt == {WIDTH{1'b1}}) && !clear;

endmodule // sat_counter

//--- leaky_bucket.sv
// leaky-bucket error counter: rises on errors, drains one step per leak period
`timescale 1ns/10ps
module leaky_bucket
   import perf_monitor_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic event_in,
   input wire logic leak_tick,
   input wire logic clear,
   output byte_type count,
   output logic saturated
);

   typedef struct packed
   {
      byte_type cnt;
   } state_type;

   state_type state_q;
   state_type state_d;

   always_comb
   begin
      state_d = state_q;
      if (clear)
      begin
         state_d.cnt = event_in ? 8'h01 : `COUNT8_RESET; // R6
      end
      else if (event_in && !leak_tick)
      begin
         if (state_q.cnt != 8'hFF) // R12
         begin
            state_d.cnt = state_q.cnt + 8'h01;
         end
      end
      else if (leak_tick && !event_in && (state_q.cnt != 8'h00))
      begin
         // leak: a bucket slowly empties while errors are sparse
         state_d.cnt = state_q.cnt - 8'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q.cnt <= `COUNT8_RESET; // R6
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign count = state_q.cnt;
   assign saturated = event_in && !leak_tick && !clear && (state_q.cnt == 8'hFF);

endmodule // leaky_bucket

//--- perf_monitor_counters_asserts.sv
// concurrent checks on the counter bank register port
`timescale 1ns/10ps
`include "perf_monitor_consts.svh"
module perf_monitor_counters_asserts
   import perf_monitor_pkg::*;
#(
   parameter int NUM_SIGNALLING = 3
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic excess_zero_event,
   input wire logic [NUM_SIGNALLING-1:0] signalling_fcs_event,
   input wire logic lapd_two_fcs_event,
   input wire logic lapd_three_fcs_event,
   input wire logic leak_tick,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   wire [11:0] ofs = addr[11:0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ****
   // a second back-to-back read must see the cleared count
   // ****
   property p_clear(logic [11:0] o, logic ev);
      rd && ofs == o && !ev ##1 rd && ofs == o |=> rdata == 8'h00;
   endproperty
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_unmapped_zero: assert property (rd && ofs == 12'h915 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_zero_high_clear: assert property (p_clear(12'h910, excess_zero_event))
      else $error("excess zero count not cleared by read");
   a_lapd_two_clear: assert property (p_clear(12'h91C, lapd_two_fcs_event))
      else $error("lapd two count not cleared by read");
   a_lapd_three_clear: assert property (p_clear(12'h92C, lapd_three_fcs_event))
      else $error("lapd three count not cleared by read");
   a_signal_one_clear: assert property (p_clear(12'h912, signalling_fcs_event[0]))
      else $error("signalling count not cleared by read");
   a_low_snap_clear: assert property (rd && ofs == 12'h911 ##1 rd && ofs == 12'h911 |=> rdata == 8'h00)
      else $error("low snapshot not cleared by read");
   a_lapd_two_count: assert property (rd && ofs == 12'h91C && !lapd_two_fcs_event ##1 !rd && !lapd_two_fcs_event
      ##1 !rd && lapd_two_fcs_event ##1 !rd && !lapd_two_fcs_event ##1 rd && ofs == 12'h91C |=> rdata == 8'h01)
      else $error("lapd two single event not counted");
   a_irq_mask_off: assert property (wr && ofs == 12'h931 && wdata == 8'h00 |=> !irq)
      else $error("irq high with mask cleared");
   cover property (rd && ofs == 12'h910);
   cover property (irq);
   cover property (leak_tick);
endmodule // perf_monitor_counters_asserts

bind perf_monitor_counters perf_monitor_counters_asserts #(.NUM_SIGNALLING(NUM_SIGNALLING)) i_chk (.clk, .resetn,
   .excess_zero_event, .signalling_fcs_event, .lapd_two_fcs_event, .lapd_three_fcs_event, .leak_tick,
   .addr, .wdata, .wr, .rd, .rdata, .irq);

//--- perf_monitor_counters_test.sv
// self-checking bench for the performance-monitor counter bank
`timescale 1ns/10ps
module perf_monitor_counters_test
   import perf_monitor_pkg::*;
;
   logic clk, resetn, wr, rd, irq;
   logic [6:0] ev;
   logic [15:0] addr;
   byte_type wdata;
   byte_type rdata;
   int n_errors, cmp_count;
   int cycles = 0;
   perf_monitor_counters i_dut (.clk, .resetn, .excess_zero_event(ev[0]), .signalling_fcs_event(ev[3:1]),
      .lapd_two_fcs_event(ev[4]), .lapd_three_fcs_event(ev[5]), .leak_tick(ev[6]),
      .addr, .wdata, .wr, .rd, .rdata, .irq);
   // ****
   // bus and event tasks
   // ****
   task automatic check(input string what, input byte_type e, input byte_type g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   // hold keeps rd up so the next read follows with no gap
   task automatic rd_reg(input logic [11:0] o, input byte_type e, input bit hold);
      @(posedge clk);
      rd <= 1'b1;
      addr <= {4'h5, o};
      @(posedge clk);
      if (!hold)
         rd <= 1'b0;
      @(negedge clk);
      check($sformatf("reg %h", o), e, rdata);
   endtask
   task automatic wr_reg(input logic [11:0] o, input byte_type d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= {4'h5, o};
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic pulse(input int b, input int n);
      repeat (n)
      begin
         @(posedge clk);
         ev[b] <= 1'b1;
         @(posedge clk);
         ev[b] <= 1'b0;
      end
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clk);
      check("irq", {7'h00, e}, {7'h00, irq});
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      rd_reg(12'h910, 8'h00, 0);
      rd_reg(12'h911, 8'h00, 0);
      rd_reg(12'h912, 8'h00, 0);
      rd_reg(12'h913, 8'h00, 0);
      rd_reg(12'h914, 8'h00, 0);
      rd_reg(12'h91C, 8'h00, 0);
      rd_reg(12'h92C, 8'h00, 0);
      rd_reg(12'h932, 8'hFF, 0);
   endtask
   task automatic t_excess;
      pulse(0, 300);
      rd_reg(12'h910, 8'h01, 0);
      pulse(0, 5);
      rd_reg(12'h911, 8'h2C, 0);
      rd_reg(12'h910, 8'h00, 0);
      rd_reg(12'h911, 8'h05, 1);
      rd_reg(12'h911, 8'h00, 0);
      rd_reg(12'h910, 8'h00, 1);
      rd_reg(12'h910, 8'h00, 0);
   endtask
   task automatic t_lapd;
      pulse(4, 3);
      pulse(5, 7);
      rd_reg(12'h91C, 8'h03, 0);
      rd_reg(12'h92C, 8'h07, 1);
      rd_reg(12'h92C, 8'h00, 0);
      rd_reg(12'h91C, 8'h00, 0);
      pulse(4, 1);
      rd_reg(12'h91C, 8'h01, 1);
      rd_reg(12'h91C, 8'h00, 0);
      pulse(4, 260);
      rd_reg(12'h91C, 8'hFF, 0);
   endtask
   task automatic t_signalling;
      pulse(1, 1);
      pulse(2, 2);
      pulse(3, 3);
      rd_reg(12'h912, 8'h01, 1);
      rd_reg(12'h912, 8'h00, 0);
      rd_reg(12'h913, 8'h02, 0);
      rd_reg(12'h914, 8'h03, 0);
      rd_reg(12'h915, 8'h00, 0);
      wr_reg(12'h912, 8'h55);
      wr_reg(12'h932, 8'h01);
      pulse(1, 4);
      pulse(6, 2);
      repeat (3) @(posedge clk);
      rd_reg(12'h912, 8'h03, 0);
   endtask
   task automatic t_irq;
      wr_reg(12'h930, 8'h1F);
      rd_reg(12'h930, 8'h00, 0);
      wr_reg(12'h931, 8'h04);
      pulse(4, 1);
      chk_irq(1'b1);
      wr_reg(12'h931, 8'h00);
      chk_irq(1'b0);
      wr_reg(12'h931, 8'h04);
      chk_irq(1'b1);
      wr_reg(12'h930, 8'h04);
      chk_irq(1'b0);
      rd_reg(12'h931, 8'h04, 0);
   endtask
   task automatic results;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // run needs about 1300 cycles; the ceiling leaves wide margin
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         results();
      end
   end
   initial
   begin
      resetn = 1'b0;
      ev = 7'h00;
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_excess();
      t_lapd();
      t_signalling();
      t_irq();
      results();
   end
endmodule // perf_monitor_counters_test
